// file: design/aagc_limit_top.sv
// Notes on behaviour
// - The mic register holds a 7-bit gain ceiling in bits 15..9, 0 dB plus 0.5 dB per code, reset to all ones.
// - One set of mic ceiling and debounce settings serves both the headset/aux and the handset input.
// - Silence mode means the input level is below the noise threshold, normal mode means at or above it.
// - Mic normal-to-silence debounce is bits 8..6, codes select 0,0.5,1,2,4,8,16,32 ms, reset 000.
// - Mic silence-to-normal debounce is bits 5..3 with the same encoding, reset 000.
// - Bits 2..0 of both AGC registers are read-only zero; software writes only zeros there.
// - Cell ceiling is bits 15..9, reset all ones, -34.5 dB at code 0 in 0.5 dB steps to code 0x44, 12 dB from 0x5d.
// - Cell normal-to-silence debounce is bits 8..6, read-only, reset 000.
// - Cell silence-to-normal debounce is bits 5..3, read-only, reset 000, same encoding.
// - With the cell AGC enable set the AGC drives the cell amplifier gain, otherwise it is off.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
module aagc_limit_top
  import aagc_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = DEB_UNIT_CYC,
  parameter int unsigned LEVEL_W     = 16
)
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]         s_axi_awprot,
  input  wire logic               s_axi_awvalid,
  output wire logic               s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output wire logic               s_axi_wready,
  output wire logic [1:0]         s_axi_bresp,
  output wire logic               s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]         s_axi_arprot,
  input  wire logic               s_axi_arvalid,
  output wire logic               s_axi_arready,
  output wire logic [31:0]        s_axi_rdata,
  output wire logic [1:0]         s_axi_rresp,
  output wire logic               s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [LEVEL_W-1:0] mic_level,
  input  wire logic [LEVEL_W-1:0] cell_level,
  output wire logic [6:0]         mic_gain_ceiling,
  output wire logic [7:0]         cell_gain_ceiling,
  output wire logic               mic_silence,
  output wire logic               cell_silence,
  output wire logic               cell_agc_active
);

  // ----------------------------------------------------------------
  // Byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] MIC_ADDR  = {MIC_REG_IDX,  2'b00};
  localparam logic [ADDR_W-1:0] CELL_ADDR = {CELL_REG_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {CTRL_REG_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] THR_ADDR  = {THR_REG_IDX,  2'b00};
  localparam logic [ADDR_W-1:0] STAT_ADDR = {STAT_REG_IDX, 2'b00};

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [6:0]         mic_ceil_reg;
  logic [2:0]         mic_enter_reg;
  logic [2:0]         mic_leave_reg;
  logic [6:0]         cell_ceil_reg;
  logic               cell_en_reg;
  logic [15:0]        thr_reg;
  logic [6:0]         mic_ceil_out_reg;
  logic [7:0]         cell_ceil_out_reg;

  // ----------------------------------------------------------------
  // Write channel state
  // ----------------------------------------------------------------
  logic               aw_got_reg;
  logic [ADDR_W-1:0]  awaddr_reg;
  logic               w_got_reg;
  logic [31:0]        wdata_reg;
  logic [3:0]         wstrb_reg;
  logic               bvalid_reg;
  logic [1:0]         bresp_reg;

  // ----------------------------------------------------------------
  // Read channel state
  // ----------------------------------------------------------------
  logic               rvalid_reg;
  logic [31:0]        rdata_reg;
  logic [1:0]         rresp_reg;

  // ----------------------------------------------------------------
  // Mode engines
  // ----------------------------------------------------------------
  aagc_mode_if mic_if ();
  aagc_mode_if cell_if ();

  wire [7:0] cell_hdb;
  wire       cell_bad;

  // Only the active mic input's level arrives here, so the one settings
  // set covers headset/aux and handset alike.
  assign mic_if.enable      = 1'b1;
  assign mic_if.below       = (mic_level < LEVEL_W'(thr_reg));
  assign mic_if.enter_code  = mic_enter_reg;
  assign mic_if.leave_code  = mic_leave_reg;

  // Cell debounce fields are fixed at zero, so cell modes follow the
  // threshold on the next clock.
  assign cell_if.enable     = cell_en_reg;
  assign cell_if.below      = (cell_level < LEVEL_W'(thr_reg));
  assign cell_if.enter_code = DEB_RST;
  assign cell_if.leave_code = DEB_RST;

  aagc_debounce #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_mic_deb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .m       (mic_if)
  );

  aagc_debounce #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_cell_deb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .m       (cell_if)
  );

  aagc_cell_ceiling u_cell_ceil (
    .code    (cell_ceil_reg),
    .hdb     (cell_hdb),
    .invalid (cell_bad)
  );

  // ----------------------------------------------------------------
  // Read words
  // ----------------------------------------------------------------
  wire [31:0] mic_word  = {16'h0000, mic_ceil_reg, mic_enter_reg, mic_leave_reg, 3'h0};
  wire [31:0] cell_word = {16'h0000, cell_ceil_reg, DEB_RST, DEB_RST, 3'h0};
  wire [31:0] ctrl_word = {31'h0000_0000, cell_en_reg};
  wire [31:0] thr_word  = {16'h0000, thr_reg};
  wire [31:0] stat_word = {28'h000_0000, cell_bad, cell_agc_active, cell_silence, mic_silence};

  // ----------------------------------------------------------------
  // Write path: address and data accepted in either order
  // ----------------------------------------------------------------
  wire              aw_hs    = s_axi_awvalid && s_axi_awready;
  wire              w_hs     = s_axi_wvalid && s_axi_wready;
  wire              aw_have  = aw_got_reg || aw_hs;
  wire              w_have   = w_got_reg || w_hs;
  wire              wr_fire  = aw_have && w_have;
  wire [ADDR_W-1:0] wr_addr  = aw_got_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0]       wr_data  = w_got_reg ? wdata_reg : s_axi_wdata;
  wire [3:0]        wr_strb  = w_got_reg ? wstrb_reg : s_axi_wstrb;
  wire              wr_mic   = wr_fire && (wr_addr == MIC_ADDR);
  wire              wr_cell  = wr_fire && (wr_addr == CELL_ADDR);
  wire              wr_ctrl  = wr_fire && (wr_addr == CTRL_ADDR) && wr_strb[0];
  wire              wr_thr   = wr_fire && (wr_addr == THR_ADDR);
  wire              wr_hit   = (wr_addr == MIC_ADDR) || (wr_addr == CELL_ADDR) || (wr_addr == CTRL_ADDR)
                            || (wr_addr == THR_ADDR) || (wr_addr == STAT_ADDR);
  wire              lo_en    = wr_strb[0];
  wire              hi_en    = wr_strb[1];

  assign s_axi_awready = aresetn && !aw_got_reg && !bvalid_reg;
  assign s_axi_wready  = aresetn && !w_got_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg <= 1'b0;
      awaddr_reg <= '0;
      w_got_reg  <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end
    else
    begin
      aw_got_reg <= aw_have && !wr_fire;
      w_got_reg  <= w_have && !wr_fire;
      if (aw_hs)
        awaddr_reg <= s_axi_awaddr;
      if (w_hs)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register updates, byte lane 1 holds ceilings, mic enter-debounce bit 8 and threshold bits 15..8, lane 0 the rest
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mic_ceil_reg  <= CEIL_RST;
      mic_enter_reg <= DEB_RST;
      mic_leave_reg <= DEB_RST;
      cell_ceil_reg <= CEIL_RST;
      cell_en_reg   <= CELL_EN_RST;
      thr_reg       <= THR_RST;
    end
    else
    begin
      if (wr_mic && hi_en)
        mic_ceil_reg <= wr_data[CEIL_LSB +: 7];
      if (wr_mic && hi_en)
        mic_enter_reg[2] <= wr_data[ENTER_LSB + 2];
      if (wr_mic && lo_en)
        mic_enter_reg[1:0] <= wr_data[ENTER_LSB +: 2];
      if (wr_mic && lo_en)
        mic_leave_reg <= wr_data[LEAVE_LSB +: 3];
      if (wr_cell && hi_en)
        cell_ceil_reg <= wr_data[CEIL_LSB +: 7];
      if (wr_ctrl)
        cell_en_reg <= wr_data[CELL_EN_BIT];
      if (wr_thr && lo_en)
        thr_reg[7:0] <= wr_data[7:0];
      if (wr_thr && hi_en)
        thr_reg[15:8] <= wr_data[15:8];
    end
  end

  // ----------------------------------------------------------------
  // Ceilings presented to the amplifiers
  // ----------------------------------------------------------------
  // With the cell AGC off its ceiling output reads zero so no stale
  // limit is applied while software owns the cell amplifier.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mic_ceil_out_reg  <= CEIL_RST;
      cell_ceil_out_reg <= 8'h00;
    end
    else
    begin
      mic_ceil_out_reg  <= mic_ceil_reg;
      cell_ceil_out_reg <= cell_en_reg ? cell_hdb : 8'h00;
    end
  end

  assign mic_gain_ceiling  = mic_ceil_out_reg;
  assign cell_gain_ceiling = cell_ceil_out_reg;
  assign mic_silence       = (mic_if.mode == AAGC_SILENCE);
  assign cell_silence      = (cell_if.mode == AAGC_SILENCE);
  assign cell_agc_active   = cell_en_reg;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire              ar_hs   = s_axi_arvalid && s_axi_arready;
  wire              rd_mic  = (s_axi_araddr == MIC_ADDR);
  wire              rd_cell = (s_axi_araddr == CELL_ADDR);
  wire              rd_ctrl = (s_axi_araddr == CTRL_ADDR);
  wire              rd_thr  = (s_axi_araddr == THR_ADDR);
  wire              rd_stat = (s_axi_araddr == STAT_ADDR);
  wire              rd_hit  = rd_mic || rd_cell || rd_ctrl || rd_thr || rd_stat;
  wire [31:0]       rd_word = rd_mic  ? mic_word
                            : rd_cell ? cell_word
                            : rd_ctrl ? ctrl_word
                            : rd_thr  ? thr_word
                            : rd_stat ? stat_word
                            : 32'h0000_0000;

  assign s_axi_arready = aresetn && !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end
    else if (ar_hs)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

endmodule : aagc_limit_top

// file: pkg/aagc_pkg.sv
package aagc_pkg;

  // ----------------------------------------------------------------
  // Clock and debounce timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DEB_UNIT_NS   = 500_000;
  localparam int unsigned DEB_UNIT_CYC  = (DEB_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map: index, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 10;
  localparam logic [7:0]  MIC_REG_IDX   = 8'h26;
  localparam logic [7:0]  CELL_REG_IDX  = 8'h27;
  localparam logic [7:0]  CTRL_REG_IDX  = 8'h28;
  localparam logic [7:0]  THR_REG_IDX   = 8'h29;
  localparam logic [7:0]  STAT_REG_IDX  = 8'h2a;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CEIL_LSB      = 9;
  localparam int unsigned ENTER_LSB     = 6;
  localparam int unsigned LEAVE_LSB     = 3;
  localparam int unsigned CELL_EN_BIT   = 0;
  localparam int unsigned ST_MIC_SIL    = 0;
  localparam int unsigned ST_CELL_SIL   = 1;
  localparam int unsigned ST_CELL_ACT   = 2;
  localparam int unsigned ST_CELL_BAD   = 3;

  // ----------------------------------------------------------------
  // Reset values and code limits
  // ----------------------------------------------------------------
  localparam logic [6:0]  CEIL_RST      = 7'h7f;
  localparam logic [2:0]  DEB_RST       = 3'h0;
  localparam logic        CELL_EN_RST   = 1'b0;
  localparam logic [15:0] THR_RST       = 16'h0000;
  localparam logic [6:0]  CELL_LAST_OK  = 7'h44;
  localparam logic [6:0]  CELL_TOP_CODE = 7'h5d;
  localparam logic [7:0]  CELL_BASE_HDB = 8'h45;
  localparam logic [7:0]  CELL_TOP_HDB  = 8'h18;

  // ----------------------------------------------------------------
  // Bus answers and modes
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef enum logic {
    AAGC_NORMAL  = 1'b0,
    AAGC_SILENCE = 1'b1
  } aagc_mode_t;

endpackage : aagc_pkg

// file: pkg/aagc_mode_if.sv
`timescale 1ns/1ps
interface aagc_mode_if;
  import aagc_pkg::*;
  logic       enable;
  logic       below;
  logic [2:0] enter_code;
  logic [2:0] leave_code;
  aagc_mode_t mode;

  modport cfg (output enable, output below, output enter_code, output leave_code, input mode);
  modport fsm (input enable, input below, input enter_code, input leave_code, output mode);
endinterface : aagc_mode_if

// file: design/aagc_debounce.sv
`timescale 1ns/1ps
module aagc_debounce
  import aagc_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = DEB_UNIT_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  aagc_mode_if.fsm m
);

  // ----------------------------------------------------------------
  // Debounce length: code 0 is immediate, then 0.5 ms doubling
  // ----------------------------------------------------------------
  function automatic logic [31:0] deb_cycles(input logic [2:0] code);
    logic [31:0] unit;
    unit = 32'(UNIT_CYCLES);
    if (code == 3'h0)
      deb_cycles = 32'h0000_0000;
    else
      deb_cycles = unit << (code - 3'h1);
  endfunction : deb_cycles

  aagc_mode_t  mode_reg;
  aagc_mode_t  mode_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  wire         in_normal = (mode_reg == AAGC_NORMAL);
  wire         toward    = in_normal ? m.below : !m.below;
  wire  [2:0]  code_sel  = in_normal ? m.enter_code : m.leave_code;
  wire  [31:0] target    = deb_cycles(code_sel);
  wire  [31:0] cnt_inc   = cnt_reg + 32'h0000_0001;
  wire         done      = toward && (cnt_inc >= target);

  always_comb
  begin
    mode_next = mode_reg;
    cnt_next  = toward ? cnt_inc : 32'h0000_0000;
    if (!m.enable)
    begin
      mode_next = AAGC_NORMAL;
      cnt_next  = 32'h0000_0000;
    end
    else
    begin
      case (mode_reg)
        AAGC_NORMAL:  if (done) mode_next = AAGC_SILENCE;
        AAGC_SILENCE: if (done) mode_next = AAGC_NORMAL;
        default:      mode_next = AAGC_NORMAL;
      endcase
      if (done)
        cnt_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_reg <= AAGC_NORMAL;
      cnt_reg  <= 32'h0000_0000;
    end
    else
    begin
      mode_reg <= mode_next;
      cnt_reg  <= cnt_next;
    end
  end

  assign m.mode = mode_reg;

endmodule : aagc_debounce

// file: design/aagc_cell_ceiling.sv
`timescale 1ns/1ps
module aagc_cell_ceiling
  import aagc_pkg::*;
(
  input  wire logic [6:0] code,
  output wire logic [7:0] hdb,
  output wire logic       invalid
);

  // ----------------------------------------------------------------
  // Half-dB ceiling, two's complement
  // ----------------------------------------------------------------
  wire       top_band = (code >= CELL_TOP_CODE);
  wire       low_band = (code <= CELL_LAST_OK);
  wire [7:0] low_hdb  = {1'b0, code} - CELL_BASE_HDB;

  // A forbidden code must not reach the amplifier as a random gain,
  // so it is held at the highest legal low-band step and flagged.
  assign invalid = !top_band && !low_band;
  assign hdb     = top_band ? CELL_TOP_HDB
                 : low_band ? low_hdb
                 : {1'b0, CELL_LAST_OK} - CELL_BASE_HDB;

endmodule : aagc_cell_ceiling

// file: dv/aagc_limit_top_assertions.sv
`timescale 1ns/1ps
module aagc_limit_top_chk
  import aagc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [7:0]  cell_gain_ceiling,
  input wire logic        cell_silence,
  input wire logic        cell_agc_active
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Reserved bits exist only in the two AGC words, so remember the address
  logic [ADDR_W-1:0] rd_addr_reg;
  always_ff @(posedge aclk)
  begin
    if (s_axi_arvalid && s_axi_arready)
      rd_addr_reg <= s_axi_araddr;
  end
  wire agc_rd    = (rd_addr_reg == {MIC_REG_IDX, 2'b00}) || (rd_addr_reg == {CELL_REG_IDX, 2'b00});
  wire rsv_clear = !agc_rd || (s_axi_rdata[2:0] == 3'h0);

  // ----------------------------------------------------------------
  // Handshake and cell-off sequences
  // ----------------------------------------------------------------
  sequence wr_pair;
    s_axi_awvalid && s_axi_awready ##0 s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence cell_off;
    !cell_agc_active [*2];
  endsequence

  wr_answer_a : assert property (wr_pair |=> s_axi_bvalid) else $error("write response missing");
  b_cause_a : assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_wvalid && s_axi_wready || s_axi_awvalid && s_axi_awready)) else $error("response without a write");
  b_hold_a : assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  wr_block_a : assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready during response");
  rd_answer_a : assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
  r_hold_a : assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_block_a : assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready during read answer");
  rd_upper_a : assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && rsv_clear)
    else $error("upper or reserved read bits set");
  err_zero_a : assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
    else $error("error read carries data");
  cell_idle_a : assert property (cell_off |-> cell_gain_ceiling == 8'h00 && !cell_silence)
    else $error("cell agc active while disabled");
  cell_range_a : assert property (cell_gain_ceiling == 8'h00 || cell_gain_ceiling >= 8'hbb
    || cell_gain_ceiling == 8'h18) else $error("cell ceiling out of range");
endmodule : aagc_limit_top_chk

bind aagc_limit_top aagc_limit_top_chk u_aagc_limit_top_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .cell_gain_ceiling(cell_gain_ceiling), .cell_silence(cell_silence),
  .cell_agc_active(cell_agc_active));

// file: dv/aagc_limit_top_tb.sv
`timescale 1ns/1ps
module aagc_limit_top_tb
  import aagc_pkg::*;
;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, mic_sil, cell_sil, cell_act;
  logic [9:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] mic_level = 16'h0100, cell_level = 16'h0100;
  logic [6:0] mic_ceil;
  logic [7:0] cell_ceil;
  logic [31:0] rd;
  int fail_count = 0, n_compared = 0, k, n;
  logic [6:0] codes [6] = '{7'h00, 7'h01, 7'h44, 7'h5d, 7'h60, 7'h7f};
  localparam logic [9:0] MIC_A = 10'h098, CELL_A = 10'h09c, CTRL_A = 10'h0a0, THR_A = 10'h0a4;
  localparam logic [9:0] STAT_A = 10'h0a8, BAD_A = 10'h3fc;

  always #5 aclk = ~aclk;

  aagc_limit_top #(.UNIT_CYCLES(4)) u_aagc_limit_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'b000), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mic_level(mic_level),
    .cell_level(cell_level), .mic_gain_ceiling(mic_ceil), .cell_gain_ceiling(cell_ceil),
    .mic_silence(mic_sil), .cell_silence(cell_sil), .cell_agc_active(cell_act));

  // ----------------------------------------------------------------
  // Bus tasks: handshakes are sampled mid-cycle to stay clear of edge races
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, output logic [1:0] r);
    logic haw, hw, hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      haw = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (haw) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) break;
    end
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    logic har, hr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      har = arvalid && arready;
      hr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (har) arvalid <= 1'b0;
      if (hr) break;
    end
    rready <= 1'b0;
  endtask : axi_rd

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rd_chk(input string what, input logic [9:0] a, input logic [31:0] exp, input logic [1:0] er);
    axi_rd(a, rd, resp);
    chk(what, exp, rd);
    chk({what, "_resp"}, {30'h0, er}, {30'h0, resp});
  endtask : rd_chk

  // Counts edges until mic silence reaches the wanted level, returns on an edge
  task automatic mic_edges(input logic want, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge aclk);
      cnt++;
      #1;
    end while (mic_sil !== want && cnt < 600);
    @(posedge aclk);
  endtask : mic_edges

  function automatic logic [7:0] cell_hdb(input logic [6:0] c);
    if (c <= 7'h44) return {1'b0, c} - 8'h45;
    if (c >= 7'h5d) return 8'h18;
    return 8'hff;
  endfunction : cell_hdb

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    $display("mismatch watchdog expected done seen hang");
    complete_run();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("mic_rst", MIC_A, 32'h0000_fe00, RESP_OKAY);
    rd_chk("cell_rst", CELL_A, 32'h0000_fe00, RESP_OKAY);
    chk("mic_ceil_rst", 32'h0000_007f, {25'h0, mic_ceil});
    axi_wr(MIC_A, 32'h1234_ab58, resp);
    rd_chk("mic_rw", MIC_A, 32'h0000_ab58, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("mic_ceil", 32'h0000_0055, {25'h0, mic_ceil});
    axi_wr(BAD_A, 32'h0000_ffff, resp);
    chk("bad_wr_resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    rd_chk("bad_rd", BAD_A, 32'h0000_0000, RESP_SLVERR);
    axi_wr(THR_A, 32'h0000_0100, resp);
    for (int c = 0; c < 8; c++)
    begin
      n = (c == 0) ? 1 : (4 << (c - 1));
      axi_wr(MIC_A, {16'h0, 7'h7f, c[2:0], c[2:0], 3'b000}, resp);
      repeat (2) @(posedge aclk);
      mic_level <= 16'h0010;
      mic_edges(1'b1, k);
      chk("enter_edges", n, k);
      mic_level <= 16'h0100;
      mic_edges(1'b0, k);
      chk("leave_edges", n, k);
    end
    axi_wr(MIC_A, 32'h0000_fe90, resp);
    mic_level <= 16'h0010;
    repeat (5) @(posedge aclk);
    mic_level <= 16'h0100;
    @(posedge aclk);
    mic_level <= 16'h0010;
    mic_edges(1'b1, k);
    chk("restart_edges", 32'd8, k);
    axi_wr(CTRL_A, 32'h0000_0001, resp);
    for (int i = 0; i < 6; i++)
    begin
      axi_wr(CELL_A, {16'h0, codes[i], 9'h1f8}, resp);
      repeat (3) @(posedge aclk);
      chk("cell_ceil", {24'h0, cell_hdb(codes[i])}, {24'h0, cell_ceil});
      rd_chk("cell_rd", CELL_A, {16'h0, codes[i], 9'h000}, RESP_OKAY);
    end
    cell_level <= 16'h0010;
    @(posedge aclk);
    #1;
    chk("cell_sil", 32'h1, {31'h0, cell_sil});
    chk("cell_act", 32'h1, {31'h0, cell_act});
    rd_chk("stat", STAT_A, 32'h0000_0007, RESP_OKAY);
    axi_wr(CTRL_A, 32'h0000_0000, resp);
    repeat (3) @(posedge aclk);
    chk("cell_off", 32'h0, {22'h0, cell_act, cell_sil, cell_ceil});
    complete_run();
  end
endmodule : aagc_limit_top_tb
